/* File: supply_regs_pkg.sv */
// constants shared by the supply register bank and its helpers
// assumes one system clock; all offsets are register pointer values on the serial bus
package supply_regs_pkg;

  // register pointer values
  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_MASK = 8'h02;
  localparam logic [7:0] ADDR_ENABLE = 8'h03;

  // values after reset or lockout, and the value read from an unmapped pointer
  localparam logic [7:0] MASK_RESET = 8'hc0;
  localparam logic [7:0] ENABLE_RESET = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;

  // serial bus target address
  localparam logic [6:0] TARGET_ADDR = 7'h48;

  // field positions inside the status, mask and enable registers
  localparam int BIT_POWER_FAIL = 7;
  localparam int BIT_LOW_BATTERY = 6;
  localparam int BIT_SUPPLY_HI = 5;
  localparam int BIT_SUPPLY_LO = 1;
  localparam int NUM_SUPPLIES = 5;
  // buck3 sits at index 2 of the five-supply vector {buck1,buck2,buck3,linreg2,linreg1}
  localparam int RAMP_SUPPLY_IDX = 2;

  // bits of a serial byte, less one
  localparam logic [2:0] LAST_BIT = 3'h7;

  // transaction states, gray coded along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_REG = 4'h2,
    ST_REG_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RDATA_ACK = 4'hc
  } bus_state_type;

endpackage

/* File: signal_sync.sv */
// two-flip-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level; no relation between bits is kept
`timescale 1ns/10ps
module signal_sync
  import supply_regs_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage is read only by the second stage
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

/* File: rail_fault_qualify.sv */
// qualifies raw undervoltage comparator levels into supply fault bits
// assumes inputs are already synchronised; purely combinational
`timescale 1ns/10ps
module rail_fault_qualify
  import supply_regs_pkg::*;
#(
  parameter int N = NUM_SUPPLIES,
  parameter int RAMP_IDX = RAMP_SUPPLY_IDX
)
(
  input wire logic [N-1:0] i_below,
  input wire logic [N-1:0] i_on,
  input wire logic i_ramp,
  output logic [N-1:0] o_fault
);

  // a disabled supply never reports a fault; buck3 is also quiet while ramping
  for (genvar g = 0; g < N; g++)
  begin : g_fault
    if (g == RAMP_IDX)
    begin : g_ramp
      assign o_fault[g] = i_below[g] & i_on[g] & ~i_ramp;
    end
    else
    begin : g_plain
      assign o_fault[g] = i_below[g] & i_on[g];
    end
  end

endmodule

/* File: supply_status_mask_enable_regs.sv */
// supply status, interrupt mask and supply enable registers behind a serial bus target
// assumes scl/sda, comparators and enable pins are asynchronous and slow against i_sys_clk
// Function
// - status bits 7,6 show power-fail, low-battery comparators
// - status bits 5..3 flag bucks below regulation
// - disabled converter reports no fault
// - buck3 fault suppressed during core voltage ramp
// - status bits 2,1 flag linear regulators
// - status at 01h, read-only, live
// - revision at 00h, fixed read-only code
// - mask bit one blocks that fault from pin
// - mask at 02h, loads c0h on lockout
// - supply on needs register bit and pin
// - lockout reloads enable register with ffh
// - enable bit held one while pin low
// - host may write enable bits 5..1
// - shared linreg pin low restores both bits
// - interrupt low while unmasked enabled fault present
// - status read releases pin, bits stay
// - unimplemented address reads ffh
// - answers serial target address 1001000
`timescale 1ns/10ps
module supply_status_mask_enable_regs
  import supply_regs_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5a // arbitrary identification value
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_supply_lockout,
  input wire logic i_power_fail_sense,
  input wire logic i_low_battery_sense,
  input wire logic i_buck1_output_low,
  input wire logic i_buck2_output_low,
  input wire logic i_buck3_output_low,
  input wire logic i_linreg2_output_low,
  input wire logic i_linreg1_output_low,
  input wire logic i_core_voltage_ramp,
  input wire logic i_buck1_enable_pin,
  input wire logic i_buck2_enable_pin,
  input wire logic i_buck3_enable_pin,
  input wire logic i_linreg_enable_pin,
  output logic o_buck1_on,
  output logic o_buck2_on,
  output logic o_buck3_on,
  output logic o_linreg2_on,
  output logic o_linreg1_on,
  output logic o_int,
  output logic o_int_oe
);

  localparam int SW = 15;

  logic [SW-1:0] async_in;
  logic [SW-1:0] sync_out;
  logic scl_s;
  logic sda_s;
  logic lockout_s;
  logic power_fail_s;
  logic low_battery_s;
  logic [NUM_SUPPLIES-1:0] below_s;
  logic ramp_s;
  logic [NUM_SUPPLIES-1:0] pin_s;
  logic defaults_load;

  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  bus_state_type state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic phase_r;
  logic rw_r;
  logic mack_r;
  logic [7:0] rx_byte;
  logic rx_state;
  logic rx_done;
  logic ptr_wr;
  logic wr_stb;
  logic rd_load;
  logic status_rd;
  logic [7:0] ptr_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic drive_nxt;

  logic [7:0] mask_r;
  logic [NUM_SUPPLIES-1:0] en_r;
  logic [NUM_SUPPLIES-1:0] en_nxt;
  logic [NUM_SUPPLIES-1:0] on_r;
  logic [NUM_SUPPLIES-1:0] fault_q;
  logic [7:0] status_r;
  logic [7:1] unmasked;
  logic [7:1] unmasked_d_r;
  logic new_fault;
  logic released_r;
  logic int_oe_r;

  // every pin-side level crosses two flops before use
  assign async_in = {i_scl, i_sda, i_supply_lockout, i_power_fail_sense, i_low_battery_sense,
                     i_buck1_output_low, i_buck2_output_low, i_buck3_output_low,
                     i_linreg2_output_low, i_linreg1_output_low, i_core_voltage_ramp,
                     i_buck1_enable_pin, i_buck2_enable_pin, i_buck3_enable_pin,
                     i_linreg_enable_pin};

  signal_sync #(
    .WIDTH(SW),
    .RESET_VAL('1)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(async_in),
    .o_sync(sync_out)
  );

  // unpack synchronised levels; one linreg pin feeds both regulators
  assign scl_s = sync_out[14];
  assign sda_s = sync_out[13];
  assign lockout_s = sync_out[12];
  assign power_fail_s = sync_out[11];
  assign low_battery_s = sync_out[10];
  assign below_s = sync_out[9:5];
  assign ramp_s = sync_out[4];
  assign pin_s = {sync_out[3:1], sync_out[0], sync_out[0]};
  assign defaults_load = i_rst | lockout_s;

  // previous bus levels for edge and condition detection
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // byte strobes derived from the transaction state
  assign rx_byte = {shift_r[6:0], sda_s};
  assign rx_state = (state_r == ST_ADDR) || (state_r == ST_REG) || (state_r == ST_WDATA);
  assign rx_done = rx_state && scl_rise && (bit_cnt_r == LAST_BIT);
  assign ptr_wr = rx_done && (state_r == ST_REG);
  assign wr_stb = rx_done && (state_r == ST_WDATA);
  assign rd_load = scl_fall && phase_r &&
                   (((state_r == ST_ADDR_ACK) && rw_r) || ((state_r == ST_RDATA_ACK) && mack_r));
  assign status_rd = rd_load && (ptr_r == ADDR_STATUS);

  // transaction sequencer: address, pointer, then write or read bytes
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      phase_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end
    else if (start_det)
    begin
      state_r <= ST_ADDR; // repeated start also lands here
      bit_cnt_r <= 3'h0;
      phase_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE;
      phase_r <= 1'b0;
    end
    else
    begin
      if (scl_rise && (rx_state || state_r == ST_RDATA))
      begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (scl_rise && rx_state)
      begin
        shift_r <= rx_byte;
      end
      case (state_r)
        ST_ADDR:
        begin
          if (rx_done)
          begin
            if (rx_byte[7:1] == TARGET_ADDR)
            begin
              state_r <= ST_ADDR_ACK;
              rw_r <= sda_s;
            end
            else
            begin
              state_r <= ST_IDLE; // not ours: stay off the bus until the next start
            end
          end
        end
        ST_REG:
        begin
          if (rx_done)
          begin
            state_r <= ST_REG_ACK;
          end
        end
        ST_WDATA:
        begin
          if (rx_done)
          begin
            state_r <= ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK:
        begin
          // phase 0 waits for the eighth falling edge, phase 1 holds the ack low
          if (scl_fall)
          begin
            phase_r <= ~phase_r;
            if (phase_r)
            begin
              bit_cnt_r <= 3'h0;
              if (state_r == ST_ADDR_ACK)
              begin
                state_r <= rw_r ? ST_RDATA : ST_REG;
              end
              else
              begin
                state_r <= ST_WDATA;
              end
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_rise && bit_cnt_r == LAST_BIT)
          begin
            state_r <= ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK:
        begin
          // phase 0 still drives bit 0, phase 1 listens to the host acknowledge
          if (scl_rise && phase_r)
          begin
            mack_r <= ~sda_s;
          end
          if (scl_fall)
          begin
            phase_r <= ~phase_r;
            if (phase_r)
            begin
              bit_cnt_r <= 3'h0;
              state_r <= mack_r ? ST_RDATA : ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // register pointer, auto-incremented after every written byte and as every read byte is loaded
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ptr_r <= 8'h00;
    end
    else if (ptr_wr)
    begin
      ptr_r <= rx_byte;
    end
    else if (wr_stb || rd_load)
    begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // read data selection
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] val;
    val = UNMAPPED_READ;
    case (addr)
      ADDR_REVISION: val = REVISION_CODE;
      ADDR_STATUS: val = status_r;
      ADDR_MASK: val = mask_r;
      ADDR_ENABLE: val = {2'b11, en_r, 1'b1};
      default: val = UNMAPPED_READ;
    endcase
    return val;
  endfunction

  // transmit shifter: loaded at the start of each read byte, msb first
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      tx_r <= 8'hff;
    end
    else if (rd_load)
    begin
      tx_r <= read_mux(ptr_r);
    end
    else if (scl_fall && state_r == ST_RDATA)
    begin
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  // sda is only ever pulled low; a one is the pull-up
  always_comb
  begin
    drive_nxt = 1'b0;
    case (state_r)
      ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: drive_nxt = phase_r;
      ST_RDATA: drive_nxt = ~tx_r[7];
      ST_RDATA_ACK: drive_nxt = ~phase_r & ~tx_r[7];
      default: drive_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sda_oe_r <= 1'b0;
    end
    else
    begin
      sda_oe_r <= drive_nxt;
    end
  end

  // mask: bit 0 has no fault behind it and stays zero
  always_ff @(posedge i_sys_clk)
  begin
    if (defaults_load)
    begin
      mask_r <= MASK_RESET;
    end
    else if (wr_stb && ptr_r == ADDR_MASK)
    begin
      mask_r <= {rx_byte[7:1], 1'b0};
    end
  end

  // enable bits: writable, but forced back to one while their pin is low
  always_comb
  begin
    en_nxt = en_r;
    if (wr_stb && ptr_r == ADDR_ENABLE)
    begin
      en_nxt = rx_byte[BIT_SUPPLY_HI:BIT_SUPPLY_LO];
    end
    en_nxt = en_nxt | ~pin_s;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (defaults_load)
    begin
      en_r <= ENABLE_RESET[BIT_SUPPLY_HI:BIT_SUPPLY_LO];
    end
    else
    begin
      en_r <= en_nxt;
    end
  end

  // supply turn-on is the and of register bit and pin
  always_ff @(posedge i_sys_clk)
  begin
    if (defaults_load)
    begin
      on_r <= '0;
    end
    else
    begin
      on_r <= en_r & pin_s;
    end
  end

  rail_fault_qualify #(
    .N(NUM_SUPPLIES),
    .RAMP_IDX(RAMP_SUPPLY_IDX)
  ) u_qualify (
    .i_below(below_s),
    .i_on(on_r),
    .i_ramp(ramp_s),
    .o_fault(fault_q)
  );

  // live status; writes never reach it
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      status_r <= 8'h00;
    end
    else
    begin
      status_r <= {power_fail_s, low_battery_s, fault_q, 1'b0};
    end
  end

  // faults that may reach the pin
  assign unmasked = status_r[7:1] & ~mask_r[7:1];
  assign new_fault = |(unmasked & ~unmasked_d_r);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      unmasked_d_r <= '0;
    end
    else
    begin
      unmasked_d_r <= unmasked;
    end
  end

  // a status read lets the pin float; a fresh fault or full recovery re-arms it
  always_ff @(posedge i_sys_clk)
  begin
    if (defaults_load)
    begin
      released_r <= 1'b0;
    end
    else if (unmasked == '0 || new_fault)
    begin
      released_r <= 1'b0;
    end
    else if (status_rd && int_oe_r)
    begin
      released_r <= 1'b1;
    end
  end

  // open-drain interrupt, low while any unmasked fault stands and no status read has released it
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      int_oe_r <= 1'b0;
    end
    else
    begin
      int_oe_r <= (|unmasked) & ~released_r;
    end
  end

  assign o_int = 1'b0;
  assign o_int_oe = int_oe_r;
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe_r;
  assign o_buck1_on = on_r[4];
  assign o_buck2_on = on_r[3];
  assign o_buck3_on = on_r[2];
  assign o_linreg2_on = on_r[1];
  assign o_linreg1_on = on_r[0];

endmodule

/* File: supply_regs_asserts.sv */
// concurrent checks on the supply register bank top-level pins
// assumes one system clock, synchronous active-high reset, slow async inputs
`timescale 1ns/10ps
module supply_regs_asserts
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic o_sda_oe,
  input wire logic i_supply_lockout,
  input wire logic i_power_fail_sense,
  input wire logic i_low_battery_sense,
  input wire logic i_buck1_output_low,
  input wire logic i_buck2_output_low,
  input wire logic i_buck3_output_low,
  input wire logic i_linreg2_output_low,
  input wire logic i_linreg1_output_low,
  input wire logic i_core_voltage_ramp,
  input wire logic i_buck1_enable_pin,
  input wire logic i_linreg_enable_pin,
  input wire logic o_buck1_on,
  input wire logic o_linreg2_on,
  input wire logic o_linreg1_on,
  input wire logic o_int_oe
);
  // no comparator other than buck3 reports trouble
  logic calm;
  assign calm = ~(i_power_fail_sense | i_low_battery_sense | i_buck1_output_low
    | i_buck2_output_low | i_linreg2_output_low | i_linreg1_output_low);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // five cycles cover two sync flops plus the output register
  AST_BUCK1_PIN_LOW: assert property (!i_buck1_enable_pin [*5] |-> !o_buck1_on)
    else $error("buck1 on while its pin is low");
  AST_LINREG_PIN_LOW: assert property (!i_linreg_enable_pin [*5] |-> !o_linreg1_on && !o_linreg2_on)
    else $error("linear regulator on while shared pin is low");
  AST_LOCKOUT_OFF: assert property (i_supply_lockout [*5] |-> !(o_buck1_on | o_linreg2_on | o_linreg1_on))
    else $error("supply on during lockout");
  AST_PIN_RETURN: assert property (!i_buck1_enable_pin [*5] ##1 (i_buck1_enable_pin && !i_supply_lockout) [*6] |-> o_buck1_on)
    else $error("buck1 stays off after pin returns high");
  AST_INT_CALM: assert property ((calm && !i_buck3_output_low) [*5] |-> !o_int_oe)
    else $error("interrupt active without any fault");
  AST_RAMP_HIDES: assert property ((calm && i_core_voltage_ramp) [*5] |-> !o_int_oe)
    else $error("buck3 fault seen during core ramp");
  AST_SDA_SCL_LOW: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  AST_RESET_QUIET: assert property (@(posedge i_sys_clk) disable iff (1'b0) i_rst |=> !o_int_oe && !o_sda_oe && !o_buck1_on)
    else $error("outputs active during reset");
  cover property (o_int_oe);
  cover property ($rose(o_sda_oe));
  cover property (i_supply_lockout [*5]);
endmodule
bind supply_status_mask_enable_regs supply_regs_asserts supply_regs_asserts_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
  .i_supply_lockout(i_supply_lockout), .i_power_fail_sense(i_power_fail_sense),
  .i_low_battery_sense(i_low_battery_sense), .i_buck1_output_low(i_buck1_output_low),
  .i_buck2_output_low(i_buck2_output_low), .i_buck3_output_low(i_buck3_output_low),
  .i_linreg2_output_low(i_linreg2_output_low), .i_linreg1_output_low(i_linreg1_output_low),
  .i_core_voltage_ramp(i_core_voltage_ramp), .i_buck1_enable_pin(i_buck1_enable_pin),
  .i_linreg_enable_pin(i_linreg_enable_pin), .o_buck1_on(o_buck1_on),
  .o_linreg2_on(o_linreg2_on), .o_linreg1_on(o_linreg1_on), .o_int_oe(o_int_oe)
);

/* File: i2c_host_model.sv */
// serial bus host that reads and writes the supply registers
// assumes the data line has a pull-up; the device only pulls it low
`timescale 1ns/10ps
module i2c_host_model
(
  input wire logic i_sys_clk,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  localparam int Q = 8; // third of a bit in system clocks, slow enough for the sync flops
  logic low_r = 1'b0;
  logic scl_r = 1'b1;
  assign o_scl = scl_r;
  // wired-and with pull-up: a released line reads high
  assign o_sda = ~(low_r | i_sda_oe);
  task automatic tick();
    repeat (Q) @(posedge i_sys_clk);
  endtask
  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic seen);
    low_r <= ~b;
    tick();
    scl_r <= 1'b1;
    tick();
    seen = o_sda;
    scl_r <= 1'b0;
    tick();
  endtask
  task automatic start_cond();
    low_r <= 1'b0;
    tick();
    scl_r <= 1'b1;
    tick();
    low_r <= 1'b1;
    tick();
    scl_r <= 1'b0;
    tick();
  endtask
  task automatic stop_cond();
    low_r <= 1'b1;
    tick();
    scl_r <= 1'b1;
    tick();
    low_r <= 1'b0;
    tick();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // host acknowledges all but the last byte; the nack lets the device release the line
  task automatic recv(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
  task automatic write_reg(input logic [7:0] dev, input logic [7:0] p, input logic [7:0] d,
    output logic ok);
    logic a0, a1, a2;
    start_cond();
    send(dev, a0);
    send(p, a1);
    send(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send(8'h90, a0);
    send(p, a1);
    start_cond();
    send(8'h91, a2);
    recv(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // two bytes in one read: exercises the host ack path and pointer auto-increment
  task automatic read_pair(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1,
    output logic ok);
    logic a0, a1, a2;
    start_cond();
    send(8'h90, a0);
    send(p, a1);
    start_cond();
    send(8'h91, a2);
    recv(1'b0, d0);
    recv(1'b1, d1);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

/* File: supply_status_mask_enable_regs_tb.sv */
// self-checking bench for the supply register bank with a serial host model
// assumes a 125 MHz system clock and a pulled-up interrupt line
`timescale 1ns/10ps
module supply_status_mask_enable_regs_tb;
  localparam logic [7:0] REV = 8'h3c; // arbitrary identification value
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic scl, sda, sda_oe, int_oe, ok;
  logic lock = 1'b0;
  logic ramp = 1'b0;
  logic [6:0] sense = 7'h00; // pf, lb, buck1..3, linreg2, linreg1
  logic [3:0] pin = 4'hf; // buck1..3, shared linreg
  wire logic [4:0] on;
  logic [7:0] mask_m, en_m, d, rd;
  int n_mismatch = 0;
  int compares = 0;
  always #4 i_sys_clk = ~i_sys_clk;
  supply_status_mask_enable_regs #(.REVISION_CODE(REV)) supply_status_mask_enable_regs_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(),
    .o_sda_oe(sda_oe), .i_supply_lockout(lock), .i_power_fail_sense(sense[6]),
    .i_low_battery_sense(sense[5]), .i_buck1_output_low(sense[4]),
    .i_buck2_output_low(sense[3]), .i_buck3_output_low(sense[2]),
    .i_linreg2_output_low(sense[1]), .i_linreg1_output_low(sense[0]),
    .i_core_voltage_ramp(ramp), .i_buck1_enable_pin(pin[3]), .i_buck2_enable_pin(pin[2]),
    .i_buck3_enable_pin(pin[1]), .i_linreg_enable_pin(pin[0]), .o_buck1_on(on[4]),
    .o_buck2_on(on[3]), .o_buck3_on(on[2]), .o_linreg2_on(on[1]), .o_linreg1_on(on[0]),
    .o_int(), .o_int_oe(int_oe));
  i2c_host_model i2c_host_model_i (.i_sys_clk(i_sys_clk), .i_sda_oe(sda_oe), .o_scl(scl),
    .o_sda(sda));
  // reference model: pins per supply, supplies on, live status
  function automatic logic [4:0] pin5();
    return {pin[3:1], pin[0], pin[0]};
  endfunction
  function automatic logic [4:0] on_exp();
    return en_m[5:1] & pin5() & {5{~lock}};
  endfunction
  function automatic logic [7:0] st_exp();
    return {sense[6:5], sense[4:0] & on_exp() & {2'b11, ~ramp, 2'b11}, 1'b0};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    i2c_host_model_i.write_reg(8'h90, p, v, ok);
    chk("write ack", 8'h01, {7'h0, ok});
  endtask
  task automatic rd_chk(input string what, input logic [7:0] p, input logic [7:0] exp);
    i2c_host_model_i.read_reg(p, rd, ok);
    chk("read ack", 8'h01, {7'h0, ok});
    chk(what, exp, rd);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // long enough for every test with a wide margin
  initial
  begin
    repeat (80000) @(posedge i_sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(32'h0cf8790d));
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    settle();
    rd_chk("revision", 8'h00, REV);
    rd_chk("mask", 8'h02, 8'hc0);
    rd_chk("enable", 8'h03, 8'hff);
    rd_chk("unmapped", 8'h07, 8'hff);
    wr(8'h00, 8'h11);
    wr(8'h01, 8'h22);
    rd_chk("revision", 8'h00, REV);
    i2c_host_model_i.write_reg(8'h92, 8'h02, 8'h00, ok);
    chk("foreign ack", 8'h00, {7'h0, ok});
    rd_chk("mask", 8'h02, 8'hc0);
    $display("test defaults done");
    en_m = 8'hff;
    // writes happen with all comparators quiet so the pin starts fresh each round
    for (int k = 0; k < 6; k++)
    begin
      sense <= 7'h00;
      pin <= 4'($urandom);
      settle();
      en_m = en_m | {2'b00, ~pin5(), 1'b0};
      d = 8'($urandom);
      wr(8'h02, d);
      mask_m = d & 8'hfe;
      d = 8'($urandom);
      wr(8'h03, d);
      en_m = d | 8'hc1 | {2'b00, ~pin5(), 1'b0};
      rd_chk("mask", 8'h02, mask_m);
      rd_chk("enable", 8'h03, en_m);
      sense <= 7'($urandom);
      ramp <= 1'($urandom);
      settle();
      chk("supplies on", {3'h0, on_exp()}, {3'h0, on});
      chk("int", {7'h0, |(st_exp() & ~mask_m)}, {7'h0, int_oe});
      rd_chk("status", 8'h01, st_exp());
      settle();
      chk("int after read", 8'h00, {7'h0, int_oe});
      rd_chk("status kept", 8'h01, st_exp());
    end
    $display("test random rounds done");
    pin <= 4'hf;
    lock <= 1'b1;
    settle();
    chk("on in lockout", 8'h00, {3'h0, on});
    lock <= 1'b0;
    settle();
    rd_chk("mask", 8'h02, 8'hc0);
    rd_chk("enable", 8'h03, 8'hff);
    chk("on after lockout", 8'h1f, {3'h0, on});
    i2c_host_model_i.read_pair(8'h02, d, rd, ok);
    chk("pair ack", 8'h01, {7'h0, ok});
    chk("pair mask", 8'hc0, d);
    chk("pair enable", 8'hff, rd);
    $display("test lockout done");
    sense <= 7'h04;
    ramp <= 1'b1;
    settle();
    rd_chk("status in ramp", 8'h01, 8'h00);
    chk("int in ramp", 8'h00, {7'h0, int_oe});
    ramp <= 1'b0;
    settle();
    chk("int after ramp", 8'h01, {7'h0, int_oe});
    rd_chk("status after ramp", 8'h01, 8'h08);
    $display("test ramp done");
    report_and_stop();
  end
endmodule
